// ### hdl/smta_alu.sv
// Subtract and mask-test execution datapath with its opcode decode
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smta_alu (
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire logic                INSTR_VALID,
	input  wire smta_pkg::smta_instr_t INSTR,
	output logic                     READY,
	output logic [3:0]               RF_RADDR_A,
	output logic [3:0]               RF_RADDR_B,
	input  wire logic [31:0]         RF_RDATA_A,
	input  wire logic [31:0]         RF_RDATA_B,
	output logic                     RF_WE,
	output smta_pkg::smta_rfw_t      RF_WR,
	output logic                     MEM_REQ,
	output smta_pkg::smta_mem_t      MEM_CMD,
	input  wire logic                MEM_ACK,
	input  wire logic [31:0]         MEM_RDATA,
	output logic [7:0]               FLAGS,
	output logic                     DONE,
	output logic                     ILLEGAL,
	input  wire logic [3:0]          REG_ADDR,
	input  wire logic [31:0]         REG_WDATA,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	output logic [31:0]              REG_RDATA
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic smta_pkg::smta_op_t pick(input logic [11:0] v, input logic [11:0] c_sub,
		input logic [11:0] c_tcm);
		if (v == c_sub) begin
			return smta_pkg::OP_SUB;
		end else if (v == c_tcm) begin
			return smta_pkg::OP_TCM;
		end
		return smta_pkg::OP_TM;
	endfunction : pick

	function automatic smta_pkg::smta_dec_t decode(input smta_pkg::smta_instr_t in);
		smta_pkg::smta_dec_t d;
		logic [2:0]          sub3;
		logic                memform;
		d.op     = smta_pkg::OP_BAD;
		d.src    = smta_pkg::SRC_IMM;
		d.memdst = 1'b0;
		d.size   = smta_pkg::SZ_QUAD;
		d.sext   = 1'b0;
		d.am     = smta_pkg::AM_NONE;
		d.ra     = in.w0[3:0];
		d.rb     = in.w0[7:4];
		d.imm    = {in.w1, in.w2};
		sub3     = in.w0[6:4];
		memform  = 1'b0;
		unique case (in.w0[15:8])
			smta_pkg::RR_SUB, smta_pkg::RR_TCM, smta_pkg::RR_TM: begin
				d.op  = pick({4'h0, in.w0[15:8]}, {4'h0, smta_pkg::RR_SUB}, {4'h0, smta_pkg::RR_TCM});
				d.src = smta_pkg::SRC_REGB;
			end
			smta_pkg::DIR_SUB, smta_pkg::DIR_TCM, smta_pkg::DIR_TM: begin
				d.op    = pick({4'h0, in.w0[15:8]}, {4'h0, smta_pkg::DIR_SUB}, {4'h0, smta_pkg::DIR_TCM});
				d.am    = smta_pkg::AM_DIRECT;
				d.imm   = in.w0[7] ? {in.w1, in.w2} : {{16{in.w1[15]}}, in.w1};
				memform = 1'b1;
			end
			smta_pkg::IDX_SUB, smta_pkg::IDX_TCM, smta_pkg::IDX_TM: begin
				d.op    = pick({4'h0, in.w0[15:8]}, {4'h0, smta_pkg::IDX_SUB}, {4'h0, smta_pkg::IDX_TCM});
				d.am    = smta_pkg::AM_INDEX;
				sub3    = in.w1[15:13];
				d.imm   = {{19{in.w1[12]}}, in.w1[12:0]};
				memform = 1'b1;
				if (sub3 >= smta_pkg::SUB3_ST) begin
					d.ra = in.w0[7:4];
					d.rb = in.w0[3:0];
				end
			end
			default: begin
				unique case (in.w0[15:4])
					smta_pkg::FULL_IMMEDIATE_SUB, smta_pkg::FULL_IMMEDIATE_TCM, smta_pkg::FULL_IMMEDIATE_TM: begin
						d.op = pick(in.w0[15:4], smta_pkg::FULL_IMMEDIATE_SUB, smta_pkg::FULL_IMMEDIATE_TCM);
					end
					smta_pkg::IMM16_SUB, smta_pkg::IMM16_TCM, smta_pkg::IMM16_TM: begin
						d.op  = pick(in.w0[15:4], smta_pkg::IMM16_SUB, smta_pkg::IMM16_TCM);
						d.imm = {16'h0000, in.w1};
					end
					smta_pkg::IND32_SUB, smta_pkg::IND32_TCM, smta_pkg::IND32_TM: begin
						d.op = pick(in.w0[15:4], smta_pkg::IND32_SUB, smta_pkg::IND32_TCM);
					end
					smta_pkg::INDS_SUB, smta_pkg::INDS_TCM, smta_pkg::INDS_TM: begin
						d.op  = pick(in.w0[15:4], smta_pkg::INDS_SUB, smta_pkg::INDS_TCM);
						d.imm = {{16{in.w1[15]}}, in.w1};
					end
					smta_pkg::INDW_SUB, smta_pkg::INDW_TCM, smta_pkg::INDW_TM: begin
						d.op   = pick(in.w0[15:4], smta_pkg::INDW_SUB, smta_pkg::INDW_TCM);
						d.imm  = {16'h0000, in.w1};
						d.size = smta_pkg::SZ_WORD;
					end
					smta_pkg::INDB_ANY: begin
						d.imm  = {24'h000000, in.w1[7:0]};
						d.size = smta_pkg::SZ_BYTE;
						if (in.w1[10:8] == smta_pkg::BOP_SUB) begin
							d.op = smta_pkg::OP_SUB;
						end else if (in.w1[10:8] == smta_pkg::BOP_TCM) begin
							d.op = smta_pkg::OP_TCM;
						end else if (in.w1[10:8] == smta_pkg::BOP_TM) begin
							d.op = smta_pkg::OP_TM;
						end
					end
					default: begin
						d.op = smta_pkg::OP_BAD;
					end
				endcase
				if (in.w0[15:8] != 8'haa) begin
					d.am     = smta_pkg::AM_INDIR;
					d.memdst = 1'b1;
					d.rb     = in.w0[3:0];
				end
			end
		endcase
		if (memform) begin
			d.memdst = (sub3 >= smta_pkg::SUB3_ST);
			d.src    = d.memdst ? smta_pkg::SRC_REGA : smta_pkg::SRC_MEM;
			d.sext   = (sub3 == 3'h1) || (sub3 == 3'h3);
			if ((sub3 == 3'h0) || (sub3 == 3'h1) || (sub3 == 3'h5)) begin
				d.size = smta_pkg::SZ_BYTE;
			end else if ((sub3 == 3'h2) || (sub3 == 3'h3) || (sub3 == 3'h6)) begin
				d.size = smta_pkg::SZ_WORD;
			end else begin
				d.size = smta_pkg::SZ_QUAD;
			end
		end
		return d;
	endfunction : decode

	function automatic logic [31:0] extend(input smta_pkg::smta_size_t sz, input logic sx,
		input logic [31:0] v);
		unique case (sz)
			smta_pkg::SZ_BYTE: return sx ? {{24{v[7]}}, v[7:0]} : {24'h000000, v[7:0]};
			smta_pkg::SZ_WORD: return sx ? {{16{v[15]}}, v[15:0]} : {16'h0000, v[15:0]};
			default:           return v;
		endcase
	endfunction : extend

	// Operands are shifted up so one 32-bit adder serves every size
	function automatic smta_pkg::smta_calc_t calc(input smta_pkg::smta_op_t op,
		input smta_pkg::smta_size_t sz, input logic [31:0] d, input logic [31:0] s);
		smta_pkg::smta_calc_t r;
		logic [4:0]           sh;
		logic [31:0]          ds;
		logic [31:0]          ss;
		logic [31:0]          rs;
		logic [32:0]          sum;
		sh  = (sz == smta_pkg::SZ_BYTE) ? smta_pkg::SH_BYTE :
		      (sz == smta_pkg::SZ_WORD) ? smta_pkg::SH_WORD : 5'h00;
		ds  = d << sh;
		ss  = s << sh;
		sum = {1'b0, ds} + {1'b0, ~ss} + 33'h000000001;
		unique case (op)
			smta_pkg::OP_TCM: rs = ~ds & ss;
			smta_pkg::OP_TM:  rs = ds & ss;
			default:          rs = sum[31:0];
		endcase
		r.res = rs >> sh;
		r.c   = ~sum[32];
		r.z   = (rs == 32'h00000000);
		r.s   = rs[31];
		r.v   = (ds[31] ^ ss[31]) & (rs[31] ^ ds[31]);
		r.b   = (ds == 32'h00000000) || (ss == 32'h00000000);
		return r;
	endfunction : calc

	// ------------------------------------------------------------
	// State and datapath
	// ------------------------------------------------------------
	smta_pkg::smta_state_t state_q;
	smta_pkg::smta_dec_t   dec_q;
	smta_pkg::smta_dec_t   dec_in;
	smta_pkg::smta_calc_t  cr;
	smta_pkg::smta_size_t  fsize;
	logic [31:0]           rega_q;
	logic [31:0]           regb_q;
	logic [31:0]           memd_q;
	logic [31:0]           dst_v;
	logic [31:0]           src_v;
	logic [7:0]            flags_q;
	logic                  ready_q;
	logic                  done_q;
	logic                  illegal_q;
	logic                  bad_seen_q;
	logic                  accept;
	logic                  finish;

	assign dec_in = decode(INSTR);
	assign accept = INSTR_VALID && ready_q && (state_q == smta_pkg::S_IDLE);
	assign dst_v  = dec_q.memdst ? memd_q : rega_q;
	assign fsize  = dec_q.memdst ? dec_q.size : smta_pkg::SZ_QUAD;
	assign cr     = calc(dec_q.op, fsize, dst_v, src_v);
	assign finish = ((state_q == smta_pkg::S_EXEC) && !(dec_q.op == smta_pkg::OP_SUB && dec_q.memdst))
	             || ((state_q == smta_pkg::S_MWR) && MEM_ACK)
	             || (accept && dec_in.op == smta_pkg::OP_BAD);

	always_comb begin
		unique case (dec_q.src)
			smta_pkg::SRC_REGA: src_v = rega_q;
			smta_pkg::SRC_REGB: src_v = regb_q;
			smta_pkg::SRC_MEM:  src_v = extend(dec_q.size, dec_q.sext, memd_q);
			default:            src_v = dec_q.imm;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= smta_pkg::S_IDLE;
		end else begin
			unique case (state_q)
				smta_pkg::S_IDLE: begin
					if (accept && dec_in.op != smta_pkg::OP_BAD) begin
						state_q <= smta_pkg::S_RREQ;
					end
				end
				smta_pkg::S_RREQ: state_q <= smta_pkg::S_ROPS;
				smta_pkg::S_ROPS: begin
					state_q <= (dec_q.am == smta_pkg::AM_NONE) ? smta_pkg::S_EXEC : smta_pkg::S_MRD;
				end
				smta_pkg::S_MRD: begin
					if (MEM_ACK) begin
						state_q <= smta_pkg::S_EXEC;
					end
				end
				smta_pkg::S_EXEC: begin
					state_q <= (dec_q.op == smta_pkg::OP_SUB && dec_q.memdst) ?
					           smta_pkg::S_MWR : smta_pkg::S_IDLE;
				end
				smta_pkg::S_MWR: begin
					if (MEM_ACK) begin
						state_q <= smta_pkg::S_IDLE;
					end
				end
				default: state_q <= smta_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			dec_q       <= '0;
			RF_RADDR_A  <= 4'h0;
			RF_RADDR_B  <= 4'h0;
		end else if (accept) begin
			dec_q       <= dec_in;
			RF_RADDR_A  <= dec_in.ra;
			RF_RADDR_B  <= dec_in.rb;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			rega_q <= 32'h00000000;
			regb_q <= 32'h00000000;
			memd_q <= 32'h00000000;
		end else begin
			if (state_q == smta_pkg::S_ROPS) begin
				rega_q <= RF_RDATA_A;
				regb_q <= RF_RDATA_B;
			end
			if (state_q == smta_pkg::S_MRD && MEM_ACK) begin
				memd_q <= MEM_RDATA;
			end
		end
	end

	// Memory port: request held until acknowledged
	always_ff @(posedge CLK) begin
		if (RST) begin
			MEM_REQ <= 1'b0;
			MEM_CMD <= '0;
		end else if (state_q == smta_pkg::S_ROPS && dec_q.am != smta_pkg::AM_NONE) begin
			MEM_REQ       <= 1'b1;
			MEM_CMD.we    <= 1'b0;
			MEM_CMD.size  <= dec_q.size;
			MEM_CMD.wdata <= 32'h00000000;
			unique case (dec_q.am)
				smta_pkg::AM_DIRECT: MEM_CMD.addr <= dec_q.imm;
				smta_pkg::AM_INDEX:  MEM_CMD.addr <= RF_RDATA_B + dec_q.imm;
				default:             MEM_CMD.addr <= RF_RDATA_B;
			endcase
		end else if (state_q == smta_pkg::S_EXEC && dec_q.op == smta_pkg::OP_SUB && dec_q.memdst) begin
			MEM_REQ       <= 1'b1;
			MEM_CMD.we    <= 1'b1;
			MEM_CMD.wdata <= cr.res;
		end else if (MEM_ACK) begin
			MEM_REQ <= 1'b0;
		end
	end

	// Register write-back only for subtract to a register
	always_ff @(posedge CLK) begin
		if (RST) begin
			RF_WE <= 1'b0;
			RF_WR <= '0;
		end else begin
			RF_WE <= (state_q == smta_pkg::S_EXEC) && (dec_q.op == smta_pkg::OP_SUB) && !dec_q.memdst;
			if (state_q == smta_pkg::S_EXEC) begin
				RF_WR.addr <= dec_q.ra;
				RF_WR.data <= cr.res;
			end
		end
	end

	// Flags: execution wins over a software write in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			flags_q <= smta_pkg::FLAGS_RST;
		end else if (state_q == smta_pkg::S_EXEC) begin
			flags_q[smta_pkg::FL_Z]      <= cr.z;
			flags_q[smta_pkg::FL_S]      <= cr.s;
			flags_q[smta_pkg::FL_B]      <= cr.b;
			flags_q[smta_pkg::FL_UNUSED] <= 1'b0;
			if (dec_q.op == smta_pkg::OP_SUB) begin
				flags_q[smta_pkg::FL_C] <= cr.c;
				flags_q[smta_pkg::FL_V] <= cr.v;
			end else begin
				flags_q[smta_pkg::FL_V] <= 1'b0;
			end
		end else if (REG_WR && REG_ADDR == smta_pkg::REG_FLAGS) begin
			flags_q <= {REG_WDATA[7:3], 1'b0, REG_WDATA[1:0]};
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ready_q    <= 1'b1;
			done_q     <= 1'b0;
			illegal_q  <= 1'b0;
			bad_seen_q <= 1'b0;
		end else begin
			ready_q   <= finish || (ready_q && !accept);
			done_q    <= finish;
			illegal_q <= accept && dec_in.op == smta_pkg::OP_BAD;
			if (accept) begin
				bad_seen_q <= (dec_in.op == smta_pkg::OP_BAD);
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				smta_pkg::REG_FLAGS: REG_RDATA <= {24'h000000, flags_q};
				smta_pkg::REG_STAT:  REG_RDATA <= {30'h0, bad_seen_q, !ready_q};
				default:             REG_RDATA <= 32'h00000000;
			endcase
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	assign READY   = ready_q;
	assign FLAGS   = flags_q;
	assign DONE    = done_q;
	assign ILLEGAL = illegal_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	logic       in_exec;
	logic [1:0] irq_en;
	logic       dst_msb;
	logic       src_msb;
	logic [7:0] dst_byte;
	logic [7:0] src_byte;
	logic       carry_f;
	assign in_exec  = (state_q == smta_pkg::S_EXEC);
	assign irq_en   = flags_q[1:0];
	assign dst_msb  = dst_v[31];
	assign src_msb  = src_v[31];
	assign dst_byte = dst_v[7:0];
	assign src_byte = src_v[7:0];
	assign carry_f  = flags_q[smta_pkg::FL_C];

	property p_sub_dst_only;
		in_exec && dec_q.op == smta_pkg::OP_SUB && !dec_q.memdst |=> RF_WE && RF_WR.addr == dec_q.ra;
	endproperty
	a_sub_dst_only: assert property (p_sub_dst_only) else $error("subtract result not written to destination");

	property p_sub_value;
		in_exec && dec_q.op == smta_pkg::OP_SUB && !dec_q.memdst
		|=> RF_WR.data == $past(dst_v) - $past(src_v);
	endproperty
	a_sub_value: assert property (p_sub_value) else $error("subtract difference wrong");

	property p_borrow;
		in_exec && dec_q.op == smta_pkg::OP_SUB && !dec_q.memdst
		|=> FLAGS[smta_pkg::FL_C] == ($past(dst_v) < $past(src_v));
	endproperty
	a_borrow: assert property (p_borrow) else $error("carry does not match borrow");

	property p_tm_zero;
		in_exec && dec_q.op == smta_pkg::OP_TM && !dec_q.memdst
		|=> FLAGS[smta_pkg::FL_Z] == (($past(dst_v) & $past(src_v)) == 32'h00000000);
	endproperty
	a_tm_zero: assert property (p_tm_zero) else $error("mask test zero flag wrong");

	property p_overflow;
		in_exec && dec_q.op == smta_pkg::OP_SUB && !dec_q.memdst
		|=> FLAGS[smta_pkg::FL_V] == (($past(dst_msb) != $past(src_msb))
		    && ($past(dst_msb) != FLAGS[smta_pkg::FL_S]));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

	property p_blank;
		in_exec && !dec_q.memdst
		|=> FLAGS[smta_pkg::FL_B] == ($past(dst_v) == 32'h00000000 || $past(src_v) == 32'h00000000);
	endproperty
	a_blank: assert property (p_blank) else $error("blank flag wrong");

	property p_irq_kept;
		in_exec |=> FLAGS[1:0] == $past(irq_en) && !FLAGS[smta_pkg::FL_UNUSED];
	endproperty
	a_irq_kept: assert property (p_irq_kept) else $error("interrupt enable bits disturbed");

	property p_byte_tcm;
		in_exec && dec_q.op == smta_pkg::OP_TCM && dec_q.memdst && dec_q.size == smta_pkg::SZ_BYTE
		|=> FLAGS[smta_pkg::FL_Z] == ((~$past(dst_byte) & $past(src_byte)) == 8'h00);
	endproperty
	a_byte_tcm: assert property (p_byte_tcm) else $error("byte complement test flags wrong");

	property p_mask_nowrite;
		in_exec && dec_q.op != smta_pkg::OP_SUB
		|=> !RF_WE && !MEM_REQ && FLAGS[smta_pkg::FL_C] == $past(carry_f) && !FLAGS[smta_pkg::FL_V] && DONE;
	endproperty
	a_mask_nowrite: assert property (p_mask_nowrite) else $error("mask test wrote or changed carry");

	c_sub_reg:  cover property (in_exec && dec_q.op == smta_pkg::OP_SUB && !dec_q.memdst ##1 RF_WE);
	c_sub_mem:  cover property (state_q == smta_pkg::S_MWR && MEM_ACK ##1 DONE);
	c_tcm_done: cover property (in_exec && dec_q.op == smta_pkg::OP_TCM ##1 DONE);
	c_illegal:  cover property (ILLEGAL);
endmodule : smta_alu
`default_nettype wire

// ### include/smta_pkg.sv
// Package: opcodes, flag layout, carriers and states of the subtract/mask-test datapath
`default_nettype none
package smta_pkg;
	// ------------------------------------------------------------
	// Opcode prefixes and top bytes
	// ------------------------------------------------------------
	localparam logic [7:0]  RR_SUB    = 8'ha1;
	localparam logic [7:0]  RR_TCM    = 8'ha7;
	localparam logic [7:0]  RR_TM     = 8'ha6;
	localparam logic [7:0]  DIR_SUB   = 8'h71;
	localparam logic [7:0]  DIR_TCM   = 8'h77;
	localparam logic [7:0]  DIR_TM    = 8'h76;
	localparam logic [7:0]  IDX_SUB   = 8'h79;
	localparam logic [7:0]  IDX_TCM   = 8'h7f;
	localparam logic [7:0]  IDX_TM    = 8'h7e;
	localparam logic [11:0] FULL_IMMEDIATE_SUB = 12'haa9;
	localparam logic [11:0] FULL_IMMEDIATE_TCM = 12'haaf;
	localparam logic [11:0] FULL_IMMEDIATE_TM  = 12'haae;
	localparam logic [11:0] IMM16_SUB = 12'haa1;
	localparam logic [11:0] IMM16_TCM = 12'haa7;
	localparam logic [11:0] IMM16_TM  = 12'haa6;
	localparam logic [11:0] IND32_SUB = 12'hab9;
	localparam logic [11:0] IND32_TCM = 12'habf;
	localparam logic [11:0] IND32_TM  = 12'habe;
	localparam logic [11:0] INDS_SUB  = 12'had1;
	localparam logic [11:0] INDS_TCM  = 12'had7;
	localparam logic [11:0] INDS_TM   = 12'had6;
	localparam logic [11:0] INDW_SUB  = 12'hab1;
	localparam logic [11:0] INDW_TCM  = 12'hab7;
	localparam logic [11:0] INDW_TM   = 12'hab6;
	localparam logic [11:0] INDB_ANY  = 12'had9;
	localparam logic [2:0]  BOP_SUB   = 3'h1;
	localparam logic [2:0]  BOP_TCM   = 3'h7;
	localparam logic [2:0]  BOP_TM    = 3'h6;
	localparam logic [2:0]  SUB3_ST   = 3'h5;
	// ------------------------------------------------------------
	// Flag byte, shifts, register port
	// ------------------------------------------------------------
	localparam int          FL_C      = 7;
	localparam int          FL_Z      = 6;
	localparam int          FL_S      = 5;
	localparam int          FL_V      = 4;
	localparam int          FL_B      = 3;
	localparam int          FL_UNUSED = 2;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [4:0]  SH_BYTE   = 5'h18;
	localparam logic [4:0]  SH_WORD   = 5'h10;
	localparam logic [3:0]  REG_FLAGS = 4'h0;
	localparam logic [3:0]  REG_STAT  = 4'h4;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {OP_SUB, OP_TCM, OP_TM, OP_BAD} smta_op_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_QUAD} smta_size_t;
	typedef enum logic [1:0] {SRC_IMM, SRC_REGA, SRC_REGB, SRC_MEM} smta_src_t;
	typedef enum logic [1:0] {AM_NONE, AM_DIRECT, AM_INDEX, AM_INDIR} smta_am_t;
	typedef enum logic [2:0] {S_IDLE, S_RREQ, S_ROPS, S_MRD, S_EXEC, S_MWR} smta_state_t;
	typedef struct packed {
		logic [15:0] w0;
		logic [15:0] w1;
		logic [15:0] w2;
	} smta_instr_t;
	typedef struct packed {
		smta_op_t   op;
		smta_src_t  src;
		logic       memdst;
		smta_size_t size;
		logic       sext;
		smta_am_t   am;
		logic [3:0] ra;
		logic [3:0] rb;
		logic [31:0] imm;
	} smta_dec_t;
	typedef struct packed {
		logic        we;
		smta_size_t  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} smta_mem_t;
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] data;
	} smta_rfw_t;
	typedef struct packed {
		logic [31:0] res;
		logic        c;
		logic        z;
		logic        s;
		logic        v;
		logic        b;
	} smta_calc_t;
endpackage : smta_pkg
`default_nettype wire

// ### tb/smta_far.sv
// Register file and memory responder facing the datapath
`timescale 1ns/1ps
`default_nettype none
module smta_far (
	input  wire logic                CLK,
	input  wire logic [3:0]          RF_RADDR_A,
	input  wire logic [3:0]          RF_RADDR_B,
	output logic [31:0]              RF_RDATA_A,
	output logic [31:0]              RF_RDATA_B,
	input  wire logic                RF_WE,
	input  wire smta_pkg::smta_rfw_t RF_WR,
	input  wire logic                MEM_REQ,
	input  wire smta_pkg::smta_mem_t MEM_CMD,
	output logic                     MEM_ACK,
	output logic [31:0]              MEM_RDATA,
	input  wire logic [1:0]          LAG
);
	logic [31:0] regs [16];
	logic [31:0] mword;
	logic [31:0] last_addr;
	logic [1:0]  wait_q;
	assign RF_RDATA_A = regs[RF_RADDR_A];
	assign RF_RDATA_B = regs[RF_RADDR_B];
	// Inverted outside an ack, so stale data never looks valid
	assign MEM_RDATA = MEM_ACK ? mword : ~mword;
	always @(posedge CLK) begin
		if (RF_WE)
			regs[RF_WR.addr] <= RF_WR.data;
		wait_q <= MEM_REQ ? wait_q + 2'h1 : 2'h0;
		MEM_ACK <= MEM_REQ && !MEM_ACK && wait_q >= LAG;
		if (MEM_ACK && MEM_CMD.we)
			mword <= MEM_CMD.wdata;
		if (MEM_ACK)
			last_addr <= MEM_CMD.addr;
	end
endmodule : smta_far
`default_nettype wire

// ### tb/smta_alu_test.sv
// Self-checking bench of the subtract and mask-test datapath
`timescale 1ns/1ps
`default_nettype none
module smta_alu_test;
	logic                  CLK, RST, INSTR_VALID, READY, RF_WE, MEM_REQ, MEM_ACK, DONE;
	logic                  ILLEGAL, REG_WR, REG_RD;
	logic [1:0]            LAG, op;
	logic [2:0]            bop;
	logic [3:0]            RF_RADDR_A, RF_RADDR_B, REG_ADDR, d, s;
	logic [7:0]            FLAGS, f, old, im;
	logic [31:0]           RF_RDATA_A, RF_RDATA_B, MEM_RDATA, REG_WDATA, REG_RDATA, dv, sv, mw;
	smta_pkg::smta_instr_t INSTR;
	smta_pkg::smta_rfw_t   RF_WR;
	smta_pkg::smta_mem_t   MEM_CMD;
	int                    bad_count = 0;
	int                    num_checks = 0;
	smta_alu smta_alu_inst (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.READY(READY), .RF_RADDR_A(RF_RADDR_A), .RF_RADDR_B(RF_RADDR_B), .RF_WE(RF_WE),
		.RF_RDATA_A(RF_RDATA_A), .RF_RDATA_B(RF_RDATA_B), .RF_WR(RF_WR), .MEM_REQ(MEM_REQ),
		.MEM_CMD(MEM_CMD), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .FLAGS(FLAGS), .DONE(DONE),
		.ILLEGAL(ILLEGAL), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
	smta_far smta_far_inst (.CLK(CLK), .RF_RADDR_A(RF_RADDR_A), .RF_RADDR_B(RF_RADDR_B),
		.RF_RDATA_A(RF_RDATA_A), .RF_RDATA_B(RF_RDATA_B), .RF_WE(RF_WE), .RF_WR(RF_WR),
		.MEM_REQ(MEM_REQ), .MEM_CMD(MEM_CMD), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .LAG(LAG));
	// ----------------------------------------
	// Expectation and bus tasks
	// ----------------------------------------
	function automatic logic [7:0] fl(input logic [1:0] o, input logic [4:0] sh,
		input logic [31:0] dd, ss, input logic [7:0] pf);
		logic [31:0] a, b, r;
		a = dd << sh;
		b = ss << sh;
		r = o == 2'h0 ? a - b : o == 2'h1 ? ~a & b : a & b;
		return {o == 2'h0 ? a < b : pf[7], r == 0, r[31],
			o == 2'h0 && a[31] != b[31] && r[31] != a[31], a == 0 || b == 0, 1'b0, pf[1:0]};
	endfunction : fl
	task automatic check(input logic [35:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] v);
		@(posedge CLK);
		REG_WR <= wr;
		REG_RD <= !wr;
		REG_ADDR <= a;
		REG_WDATA <= v;
		@(posedge CLK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1;
		if (!wr)
			check(REG_RDATA, v);
	endtask : reg_op
	task automatic run(input logic [15:0] a, b, c);
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= {a, b, c};
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		#1;
		for (int n = 0; n < 30 && DONE !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		check(DONE, 1'b1);
		check(READY, 1'b1);
	endtask : run
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	initial begin
		void'($urandom(32'hfab4));
		{RST, INSTR_VALID, INSTR, REG_WR, REG_RD, REG_ADDR, REG_WDATA, LAG} = '0;
		RST = 1'b1;
		for (int i = 0; i < 16; i++)
			smta_far_inst.regs[i] = $urandom;
		smta_far_inst.regs[1] = 32'h0;
		smta_far_inst.regs[2] = 32'h80000000;
		smta_far_inst.regs[3] = 32'h1;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		reg_op(1'b0, 4'h0, 32'h0);
		reg_op(1'b1, 4'h0, 32'hff);
		reg_op(1'b0, 4'h0, 32'hfb);
		reg_op(1'b0, 4'h8, 32'h0);
		// Corners first: signed overflow, then a zero source
		for (int i = 0; i < 36; i++) begin
			// Register file takes the write-back one edge after DONE
			@(posedge CLK);
			#1;
			op = i < 6 ? 2'(i % 3) : 2'($urandom_range(2));
			d = i < 3 ? 4'h2 : i < 6 ? 4'h4 : 4'($urandom);
			s = i < 3 ? 4'h3 : i < 6 ? 4'h1 : 4'($urandom);
			dv = smta_far_inst.regs[d];
			sv = smta_far_inst.regs[s];
			f = fl(op, 5'h0, dv, sv, FLAGS);
			run({op == 0 ? smta_pkg::RR_SUB : op == 1 ? smta_pkg::RR_TCM : smta_pkg::RR_TM, s, d},
				16'h0, 16'h0);
			check(FLAGS, f);
			check(RF_WE, op == 2'h0);
			if (op == 2'h0)
				check(RF_WR, {d, dv - sv});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK);
			#1;
			mw = $urandom;
			dv = smta_far_inst.regs[7];
			sv = k ? {16'h0, mw[15:0]} : mw;
			f = fl(2'h0, 5'h0, dv, sv, FLAGS);
			run({k ? smta_pkg::IMM16_SUB : smta_pkg::FULL_IMMEDIATE_SUB, 4'h7},
				k ? mw[15:0] : mw[31:16], k ? 16'h0 : mw[15:0]);
			check(RF_WR, {4'h7, dv - sv});
			check(FLAGS, f);
		end
		// Byte memory forms at every answer delay, last one undecodable
		for (int k = 0; k < 6; k++) begin
			mw = $urandom;
			im = $urandom;
			smta_far_inst.mword = mw;
			LAG <= k[1:0];
			old = FLAGS;
			bop = k == 2 ? smta_pkg::BOP_SUB : k == 3 ? smta_pkg::BOP_TCM : k == 4 ? smta_pkg::BOP_TM : 3'h2;
			op = k == 1 || k == 4 ? 2'h2 : k == 3 ? 2'h1 : 2'h0;
			sv = k > 1 ? {24'h0, im} : smta_far_inst.regs[5];
			f = k == 5 ? old : fl(op, smta_pkg::SH_BYTE, {24'h0, mw[7:0]}, sv, old);
			run(k > 1 ? {smta_pkg::INDB_ANY, 4'h5} : {k ? smta_pkg::DIR_TM : smta_pkg::DIR_SUB, 8'h55},
				k > 1 ? {5'h0, bop, im} : 16'hb034, 16'h0);
			check(ILLEGAL, k == 5);
			@(posedge CLK);
			#1;
			check(FLAGS, f);
			check(smta_far_inst.mword[7:0], op == 0 && k < 5 ? 8'(mw[7:0] - sv[7:0]) : mw[7:0]);
			if (k == 0)
				check(smta_far_inst.last_addr, 32'hffffb034);
		end
		reg_op(1'b0, 4'h4, 32'h2);
		stop_test();
	end
endmodule : smta_alu_test
`default_nettype wire
